// ### dwp_top.sv
// Digital line and eight-line group I/O with arbitration and wait engine.
// Assumes synchronous field inputs and an AHB-Lite master of word accesses.
//
// The implementer's own choices: register access over AHB-Lite and the address map.
`timescale 1ns/10ps
// Summary of operation
// - Lines are grouped eight to a group; a group access moves eight lines.
// - Connector 0 has two groups; connectors 1 and 2 five each, LSB lowest.
// - Any-edge wait stalls until the line changes either way or times out.
// - Timeout zero ends at once, negative waits forever, positive counts ticks.
// - Falling-edge wait stalls until the line goes high to low.
// - Rising-edge wait stalls until the line goes low to high.
// - High-level wait completes once the line is high, even at once.
// - Low-level wait completes once the line is low, even at once.
// - The timeout counts device clock cycles.
// - Every line and trigger has own value and enable; driven only if enabled.
// - Access by several parties is arbitrated, mode chosen per group.
// - Reference lock never changes the device clock frequency.
// - Reference clock is a read-only input with no output path.
module dwp_top
  import dwp_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic                  hsel,
  input  wire logic [ADDR_W-1:0]     haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  input  wire logic [NUM_LINES-1:0]  lineIn,
  output logic [NUM_LINES-1:0]       lineOut,
  output logic [NUM_LINES-1:0]       lineOe,
  input  wire logic [NUM_LINES-1:0]  userOut,
  input  wire logic [NUM_LINES-1:0]  userOe,
  input  wire logic [NUM_GROUPS-1:0] userReq,
  input  wire logic [NUM_TRIG-1:0]   trigIn,
  output logic [NUM_TRIG-1:0]        trigOut,
  output logic [NUM_TRIG-1:0]        trigOe,
  input  wire logic                  starIn,
  output logic                       starOut,
  output logic                       starOe,
  input  wire logic                  refClkIn,
  output logic                       waitBusy,
  output logic                       waitDone,
  output logic                       waitTimedOut,
  output logic                       irq
);

  // ----------------------------------------------------------------------
  // Bus slave phases
  // ----------------------------------------------------------------------
  logic              accept;
  logic              wrPend;
  logic              rdPend;
  logic [ADDR_W-1:0] wrAddr;
  logic [ADDR_W-1:0] rdAddr;
  logic [31:0]       rdMux;

  assign accept = hsel && htrans[1] && hready;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wrPend    <= 1'b0;
      rdPend    <= 1'b0;
      wrAddr    <= '0;
      rdAddr    <= '0;
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
      hrdata    <= '0;
    end else begin
      wrPend    <= accept && hwrite;
      rdPend    <= accept && !hwrite;
      hreadyout <= !(accept && !hwrite);
      hresp     <= HRESP_OKAY;
      if (accept) begin
        wrAddr <= haddr;
        rdAddr <= haddr;
      end
      if (rdPend) hrdata <= rdMux;
    end
  end

  // ----------------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------------
  logic                   wPort;
  logic                   wLine;
  logic                   wTrig;
  logic                   wArb;
  logic                   wWait;
  logic                   wTmo;
  logic                   wStat;
  logic                   wMask;
  logic [GROUP_IDX_W-1:0] wGroup;
  logic [LINE_IDX_W-1:0]  wLineIdx;
  logic                   groupOk;
  logic                   lineOk;
  logic                   kindOk;
  dwp_wait_e              wKind;

  assign wPort    = wrPend && (wrAddr == REG_PORT_CTRL);
  assign wLine    = wrPend && (wrAddr == REG_LINE_CTRL);
  assign wTrig    = wrPend && (wrAddr == REG_TRIG_CTRL);
  assign wArb     = wrPend && (wrAddr == REG_ARB_MODE);
  assign wWait    = wrPend && (wrAddr == REG_WAIT_CTRL);
  assign wTmo     = wrPend && (wrAddr == REG_WAIT_TMO);
  assign wStat    = wrPend && (wrAddr == REG_IRQ_STATUS);
  assign wMask    = wrPend && (wrAddr == REG_IRQ_MASK);
  assign wGroup   = hwdata[PC_IDX_LSB +: GROUP_IDX_W];
  assign wLineIdx = hwdata[LINE_IDX_W-1:0];
  assign groupOk  = (32'(wGroup) < NUM_GROUPS);
  assign lineOk   = (32'(wLineIdx) < NUM_LINES);
  assign wKind    = dwp_wait_e'(hwdata[WC_KIND_LSB +: 3]);
  assign kindOk   = (hwdata[WC_KIND_LSB +: 3] <= WAIT_LOW);

  // ----------------------------------------------------------------------
  // Software output registers
  // ----------------------------------------------------------------------
  logic [NUM_LINES-1:0]   busOut;
  logic [NUM_LINES-1:0]   busOe;
  logic [GROUP_IDX_W-1:0] groupSel;
  logic [LINE_IDX_W-1:0]  lineSel;
  logic [NUM_GROUPS-1:0]  arbMode;
  logic [LINE_IDX_W-1:0]  groupBase;
  logic [LINE_IDX_W-1:0]  selBase;

  // Group g holds lines 8g..8g+7, lowest line in the LSB
  assign groupBase = {wGroup, 3'b000};
  assign selBase   = {groupSel, 3'b000};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      busOut   <= '0;
      busOe    <= '0;
      groupSel <= '0;
      lineSel  <= '0;
      arbMode  <= '0;
    end else begin
      if (wPort && groupOk) begin
        groupSel <= wGroup;
        busOut[groupBase +: LINES_PER_GROUP] <= hwdata[PC_DATA_LSB +: 8];
        busOe[groupBase +: LINES_PER_GROUP]  <= hwdata[PC_EN_LSB +: 8];
      end
      if (wLine && lineOk) begin
        lineSel          <= wLineIdx;
        busOut[wLineIdx] <= hwdata[LC_VAL_BIT];
        busOe[wLineIdx]  <= hwdata[LC_EN_BIT];
      end
      if (wArb) arbMode <= hwdata[NUM_GROUPS-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Per-group arbitration and line drivers
  // ----------------------------------------------------------------------
  logic [NUM_GROUPS-1:0] userWins;
  logic [NUM_LINES-1:0]  drvOut;
  logic [NUM_LINES-1:0]  drvOe;

  genvar g;
  generate
    for (g = 0; g < NUM_GROUPS; g++) begin : g_group
      // Mode 1 lets a requesting user own the group, mode 0 keeps software
      assign userWins[g] = arbMode[g] && userReq[g];
      assign drvOut[g*8 +: 8] = userWins[g] ? userOut[g*8 +: 8]
                                            : busOut[g*8 +: 8];
      assign drvOe[g*8 +: 8]  = userWins[g] ? userOe[g*8 +: 8]
                                            : busOe[g*8 +: 8];
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (rst) begin
      lineOut <= '0;
      lineOe  <= '0;
    end else begin
      lineOut <= drvOut;
      lineOe  <= drvOe;
    end
  end

  // ----------------------------------------------------------------------
  // Triggers, star and reference
  // ----------------------------------------------------------------------
  logic refSample;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      trigOut   <= '0;
      trigOe    <= '0;
      starOut   <= 1'b0;
      starOe    <= 1'b0;
      refSample <= 1'b0;
    end else begin
      // Reference only sampled as data; core clock stays as it is
      refSample <= refClkIn;
      if (wTrig) begin
        trigOut <= hwdata[NUM_TRIG-1:0];
        trigOe  <= hwdata[TC_EN_LSB +: NUM_TRIG];
        starOut <= hwdata[TC_STAR_BIT];
        // Star enable left to software; must stay low in slot two
        starOe  <= hwdata[TC_STEN_BIT];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Wait engine
  // ----------------------------------------------------------------------
  logic [LINE_IDX_W-1:0] waitLine;
  logic                  waitStart;
  dwp_wait_req_s         waitReq;
  dwp_wait_rsp_s         waitRsp;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      waitLine  <= '0;
      waitStart <= 1'b0;
      waitReq   <= '{kind: WAIT_ANY, timeout: TMO_RESET};
    end else begin
      waitStart <= 1'b0;
      if (wTmo && !waitRsp.busy) waitReq.timeout <= hwdata;
      if (wWait && lineOk && kindOk && !waitRsp.busy && !waitStart) begin
        waitLine     <= wLineIdx;
        waitReq.kind <= wKind;
        waitStart    <= 1'b1;
      end
    end
  end

  dwp_wait_unit u_wait (
    .core_clk   (core_clk),
    .rst        (rst),
    .start      (waitStart),
    .req        (waitReq),
    .lineSample (lineIn[waitLine]),
    .rsp        (waitRsp)
  );

  // ----------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------
  logic [IRQ_W-1:0] irqStatus;
  logic [IRQ_W-1:0] irqMask;
  logic [IRQ_W-1:0] irqSet;
  logic [IRQ_W-1:0] irqClr;

  assign irqSet[IRQ_HIT_BIT] = waitRsp.done && !waitRsp.timedOut;
  assign irqSet[IRQ_TO_BIT]  = waitRsp.done && waitRsp.timedOut;
  assign irqClr = wStat ? hwdata[IRQ_W-1:0] : '0;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irqStatus    <= '0;
      irqMask      <= '0;
      irq          <= 1'b0;
      waitBusy     <= 1'b0;
      waitDone     <= 1'b0;
      waitTimedOut <= 1'b0;
    end else begin
      // Set beats a same-cycle clear
      irqStatus    <= (irqStatus & ~irqClr) | irqSet;
      irq          <= |(irqStatus & irqMask);
      waitBusy     <= waitRsp.busy || waitStart;
      waitDone     <= waitRsp.done;
      waitTimedOut <= waitRsp.timedOut;
      if (wMask) irqMask <= hwdata[IRQ_W-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  always_comb begin
    rdMux = '0;
    unique case (rdAddr)
      REG_PORT_CTRL: begin
        rdMux[PC_DATA_LSB +: 8] = lineIn[selBase +: 8];
        rdMux[PC_EN_LSB +: 8]   = busOe[selBase +: 8];
        rdMux[PC_OUT_LSB +: 8]  = busOut[selBase +: 8];
        rdMux[PC_IDX_LSB +: GROUP_IDX_W] = groupSel;
      end
      REG_LINE_CTRL: begin
        rdMux[LINE_IDX_W-1:0] = lineSel;
        rdMux[LC_VAL_BIT]     = busOut[lineSel];
        rdMux[LC_EN_BIT]      = busOe[lineSel];
        rdMux[LC_IN_BIT]      = lineIn[lineSel];
      end
      REG_TRIG_CTRL: begin
        rdMux[NUM_TRIG-1:0]           = trigIn;
        rdMux[TC_EN_LSB +: NUM_TRIG]  = trigOe;
        rdMux[TC_STAR_BIT]            = starIn;
        rdMux[TC_STEN_BIT]            = starOe;
        rdMux[TC_REF_BIT]             = refSample;
      end
      REG_ARB_MODE:   rdMux[NUM_GROUPS-1:0] = arbMode;
      REG_WAIT_CTRL: begin
        rdMux[LINE_IDX_W-1:0]  = waitLine;
        rdMux[WC_KIND_LSB +: 3] = waitReq.kind;
        rdMux[WC_BUSY_BIT]      = waitRsp.busy || waitStart;
        rdMux[WC_TO_BIT]        = waitRsp.timedOut;
      end
      REG_WAIT_TMO:   rdMux = waitReq.timeout;
      REG_IRQ_STATUS: rdMux[IRQ_W-1:0] = irqStatus;
      REG_IRQ_MASK:   rdMux[IRQ_W-1:0] = irqMask;
      default:        rdMux = '0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cbt @(posedge core_clk); endclocking
  default disable iff (rst);

  a_group_write: assert property (
    (wPort && groupOk && !(wLine && lineOk))
      |=> (busOut[$past(groupBase) +: 8] == $past(hwdata[7:0])))
    else $error("group write did not move eight lines");
  a_arb_user: assert property (
    (arbMode[0] && userReq[0]) |=> (lineOe[7:0] == $past(userOe[7:0])))
    else $error("user did not win an arbitrated group");
  a_read_wait: assert property (
    !hreadyout |=> hreadyout)
    else $error("read wait state longer than one cycle");

  c_group_write: cover property (wPort && groupOk);
  c_irq_raise: cover property (!irq ##1 irq);

endmodule

// ### dwp_pkg.sv
// Shared constants, register map and carrier types of the digital wait port.
// Assumes a single 125 MHz core clock and a word-only AHB-Lite master.
package dwp_pkg;

  // ----------------------------------------------------------------------
  // Line and group geometry
  // ----------------------------------------------------------------------
  localparam int LINES_PER_GROUP = 8;
  localparam int CONN0_GROUPS    = 2;
  localparam int CONNX_GROUPS    = 5;
  localparam int NUM_GROUPS      = CONN0_GROUPS + 2 * CONNX_GROUPS;
  localparam int NUM_LINES       = NUM_GROUPS * LINES_PER_GROUP;
  localparam int CONN1_BASE      = CONN0_GROUPS * LINES_PER_GROUP;
  localparam int CONN2_BASE      = CONN1_BASE + CONNX_GROUPS * LINES_PER_GROUP;
  localparam int NUM_TRIG        = 8;
  localparam int LINE_IDX_W      = 7;
  localparam int GROUP_IDX_W     = 4;
  localparam int TIMEOUT_W       = 32;
  localparam int ADDR_W          = 8;

  // ----------------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_PORT_CTRL  = 8'h00;
  localparam logic [ADDR_W-1:0] REG_LINE_CTRL  = 8'h04;
  localparam logic [ADDR_W-1:0] REG_TRIG_CTRL  = 8'h08;
  localparam logic [ADDR_W-1:0] REG_ARB_MODE   = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_WAIT_CTRL  = 8'h10;
  localparam logic [ADDR_W-1:0] REG_WAIT_TMO   = 8'h14;
  localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK   = 8'h1C;

  localparam int PC_DATA_LSB  = 0;
  localparam int PC_EN_LSB    = 8;
  localparam int PC_OUT_LSB   = 16;
  localparam int PC_IDX_LSB   = 24;
  localparam int LC_VAL_BIT   = 8;
  localparam int LC_EN_BIT    = 9;
  localparam int LC_IN_BIT    = 10;
  localparam int TC_EN_LSB    = 8;
  localparam int TC_STAR_BIT  = 16;
  localparam int TC_STEN_BIT  = 17;
  localparam int TC_REF_BIT   = 24;
  localparam int WC_KIND_LSB  = 8;
  localparam int WC_BUSY_BIT  = 16;
  localparam int WC_TO_BIT    = 17;
  localparam int IRQ_HIT_BIT  = 0;
  localparam int IRQ_TO_BIT   = 1;
  localparam int IRQ_W        = 2;

  localparam logic [TIMEOUT_W-1:0] TMO_RESET = 32'h0000_0000;
  localparam logic [1:0]           HTRANS_NONSEQ = 2'h2;
  localparam logic                 HRESP_OKAY    = 1'b0;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    WAIT_ANY  = 3'h0,
    WAIT_FALL = 3'h1,
    WAIT_RISE = 3'h2,
    WAIT_HIGH = 3'h3,
    WAIT_LOW  = 3'h4
  } dwp_wait_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } dwp_wstate_e;

  typedef struct packed {
    dwp_wait_e             kind;
    logic [TIMEOUT_W-1:0]  timeout;
  } dwp_wait_req_s;

  typedef struct packed {
    logic busy;
    logic done;
    logic timedOut;
  } dwp_wait_rsp_s;

endpackage

// ### dwp_wait_unit.sv
// Edge and level wait engine with a tick-counted timeout.
// Assumes the request stays stable while busy and the line is synchronous.
`timescale 1ns/10ps
module dwp_wait_unit
  import dwp_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire logic          start,
  input  wire dwp_wait_req_s req,
  input  wire logic          lineSample,
  output dwp_wait_rsp_s      rsp
);

  dwp_wstate_e          state;
  dwp_wstate_e          next_state;
  dwp_wait_e            kind;
  logic                 prevLevel;
  logic [TIMEOUT_W-1:0] remain;
  logic                 hit;
  logic                 expired;
  logic                 unlimited;

  function automatic logic waitHit(input dwp_wait_e k, input logic prv,
                                   input logic cur);
    unique case (k)
      WAIT_ANY:  waitHit = prv ^ cur;
      WAIT_FALL: waitHit = prv & ~cur;
      WAIT_RISE: waitHit = ~prv & cur;
      WAIT_HIGH: waitHit = cur;
      WAIT_LOW:  waitHit = ~cur;
      default:   waitHit = 1'b0;
    endcase
  endfunction

  assign hit       = (state == ST_WAIT) && waitHit(kind, prevLevel, lineSample);
  assign unlimited = remain[TIMEOUT_W-1];
  assign expired   = (state == ST_WAIT) && !unlimited && (remain == '0);

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (start) next_state = ST_WAIT;
      ST_WAIT: if (hit || expired) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state     <= ST_IDLE;
      kind      <= WAIT_ANY;
      prevLevel <= 1'b0;
      remain    <= TMO_RESET;
      rsp       <= '0;
    end else begin
      state     <= next_state;
      prevLevel <= lineSample;
      rsp.busy  <= (next_state == ST_WAIT);
      rsp.done  <= hit || expired;
      if (start && state == ST_IDLE) begin
        kind         <= req.kind;
        remain       <= req.timeout;
        rsp.timedOut <= 1'b0;
      end else if (state == ST_WAIT) begin
        if (hit || expired) rsp.timedOut <= !hit;
        if (!unlimited && remain != '0) remain <= remain - 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [TIMEOUT_W-1:0] waitCycles;
  logic [TIMEOUT_W-1:0] initTmo;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      waitCycles <= '0;
      initTmo    <= '0;
    end else if (start && state == ST_IDLE) begin
      waitCycles <= '0;
      initTmo    <= req.timeout;
    end else if (state == ST_WAIT) begin
      waitCycles <= waitCycles + 1'b1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_zero_tmo_ends: assert property (
    (start && state == ST_IDLE && req.timeout == '0) |-> ##2 rsp.done)
    else $error("zero timeout did not end the wait at once");
  a_negative_never: assert property (
    (rsp.done && rsp.timedOut) |-> !$past(unlimited))
    else $error("unlimited wait timed out");
  a_tick_count: assert property (
    (rsp.done && rsp.timedOut) |-> (waitCycles == initTmo + 1'b1))
    else $error("timeout did not match the tick count");
  a_any_edge: assert property (
    (rsp.done && !rsp.timedOut && kind == WAIT_ANY)
      |-> ($past(lineSample) != $past(prevLevel)))
    else $error("any-edge wait ended without a change");
  a_fall_edge: assert property (
    (rsp.done && !rsp.timedOut && kind == WAIT_FALL)
      |-> ($past(prevLevel) && !$past(lineSample)))
    else $error("falling wait ended without a fall");
  a_rise_edge: assert property (
    (rsp.done && !rsp.timedOut && kind == WAIT_RISE)
      |-> (!$past(prevLevel) && $past(lineSample)))
    else $error("rising wait ended without a rise");
  a_high_level: assert property (
    (state == ST_WAIT && kind == WAIT_HIGH && lineSample)
      |=> (rsp.done && !rsp.timedOut))
    else $error("high level not taken at once");
  a_low_level: assert property (
    (state == ST_WAIT && kind == WAIT_LOW && !lineSample)
      |=> (rsp.done && !rsp.timedOut))
    else $error("low level not taken at once");
  a_done_pulse: assert property (
    rsp.done |=> (!rsp.done && !rsp.busy))
    else $error("done was not a single pulse");

  c_timeout: cover property (rsp.done && rsp.timedOut);
  c_rise_hit: cover property (rsp.done && !rsp.timedOut && kind == WAIT_RISE);
  c_long_wait: cover property (state == ST_WAIT && unlimited [*8]);

endmodule

// ### dwp_field_model.sv
// Field side of the line pins: loops driven lines back as inputs.
// Assumes the bench sets the level of every undriven line.
`timescale 1ns/10ps
module dwp_field_model
  import dwp_pkg::*;
(
  input  wire logic [NUM_LINES-1:0] lineOut,
  input  wire logic [NUM_LINES-1:0] lineOe,
  input  wire logic [NUM_LINES-1:0] extLevel,
  output logic      [NUM_LINES-1:0] lineIn
);
  // Driven lines read back, released lines show the field level
  assign lineIn = (lineOut & lineOe) | (extLevel & ~lineOe);
endmodule

// ### test_digital_io_wait_port.sv
// Self-checking bench of the digital wait port over AHB-Lite.
// Assumes dwp_pkg, dwp_top and dwp_field_model are compiled first.
`timescale 1ns/10ps
`define CHK(a, b) begin cmpCount++; if ((a) !== (b)) begin failCount++; \
  $display("Error t=%0t got=%h exp=%h", $time, a, b); end end
module test_digital_io_wait_port
  import dwp_pkg::*;
;
  logic                  core_clk = 1'h0;
  logic                  rst = 1'h1;
  logic                  hsel = 1'h0;
  logic                  hwrite = 1'h0;
  logic                  refClkIn = 1'h0;
  logic [7:0]            haddr = 8'h00;
  logic [1:0]            htrans = 2'h0;
  logic [31:0]           hwdata = 32'h0, hrdata, rdv;
  logic                  hreadyout, hresp, irq, starOut, starOe;
  logic                  waitBusy, waitDone, waitTimedOut;
  logic [NUM_LINES-1:0]  lineIn, lineOut, lineOe;
  logic [NUM_LINES-1:0]  ext = '0, userOut = '0, userOe = '0;
  logic [NUM_GROUPS-1:0] userReq = '0;
  logic [NUM_TRIG-1:0]   trigIn = 8'h00, trigOut, trigOe;
  int                    failCount = 0, cmpCount = 0, cyc = 0;

  always #4 core_clk = ~core_clk;

  dwp_top uut (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .lineIn(lineIn), .lineOut(lineOut), .lineOe(lineOe),
    .userOut(userOut), .userOe(userOe), .userReq(userReq), .trigIn(trigIn),
    .trigOut(trigOut), .trigOe(trigOe), .starIn(1'h0), .starOut(starOut),
    .starOe(starOe), .refClkIn(refClkIn), .waitBusy(waitBusy),
    .waitDone(waitDone), .waitTimedOut(waitTimedOut), .irq(irq));

  dwp_field_model field (.lineOut(lineOut), .lineOe(lineOe),
    .extLevel(ext), .lineIn(lineIn));

  // ----------------------------------------------------------------------
  // Bus and wait tasks
  // ----------------------------------------------------------------------
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
    hsel <= 1'h1; haddr <= a; htrans <= HTRANS_NONSEQ; hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'h1);
    htrans <= 2'h0; hsel <= 1'h0; hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'h1);
    rdv = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'h1, d);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    xfer(a, 1'h0, 32'h0);
    `CHK({hresp, rdv}, {HRESP_OKAY, e})
  endtask

  // Line 40 is never driven, so the bench owns its level
  task automatic waitRun(input logic [2:0] k, input logic [31:0] t,
                         input int tog, input logic expTo, input int expN);
    int n;
    n = 0;
    wr(REG_WAIT_TMO, t);
    wr(REG_WAIT_CTRL, {21'h0, k, 1'h0, 7'h28});
    do begin
      @(posedge core_clk);
      n++;
      if (n == tog) ext[40] <= ~ext[40];
      if (n == 2) `CHK(waitBusy, 1'h1)
    end while (waitDone !== 1'h1 && n < 300);
    `CHK({waitDone, waitBusy}, 2'h2)
    `CHK(waitTimedOut, expTo)
    if (expN > 0) `CHK(n, expN)
    if (tog > 0) `CHK(n > tog, 1'h1)
    @(posedge core_clk);
    `CHK(waitDone, 1'h0)
  endtask

  task automatic summarize;
    $display("Compared %0d, mismatched %0d", cmpCount, failCount);
    if (failCount == 0 && cmpCount > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 4000) begin
      failCount++;
      summarize;
    end
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'h0;
    @(posedge core_clk);
    `CHK({hreadyout, lineOe, irq}, {1'h1, 96'h0, 1'h0})
    // Group path on groups 2 and 11, line path on group 0 only
    wr(REG_PORT_CTRL, 32'h0200_FFA5);
    wr(REG_PORT_CTRL, 32'h0B00_F03C);
    wr(REG_PORT_CTRL, 32'h0C00_FFFF);
    repeat (2) @(posedge core_clk);
    `CHK(lineOe, {8'hF0, 64'h0, 8'hFF, 16'h0})
    `CHK({lineOut[95:88], lineOut[23:16]}, 16'h3CA5)
    rdChk(REG_PORT_CTRL, 32'h0B3C_F030);
    wr(REG_LINE_CTRL, 32'h0000_0303);
    repeat (2) @(posedge core_clk);
    `CHK({lineOut[3], lineOe[3]}, 2'h3)
    rdChk(REG_LINE_CTRL, 32'h0000_0703);
    userOut[7:0] <= 8'h5A;
    userOe[7:0] <= 8'hFF;
    userReq[0] <= 1'h1;
    wr(REG_ARB_MODE, 32'h0000_0001);
    repeat (2) @(posedge core_clk);
    `CHK({lineOut[7:0], lineOe[7:0]}, 16'h5AFF)
    userReq[0] <= 1'h0;
    repeat (3) @(posedge core_clk);
    `CHK({lineOut[7:0], lineOe[7:0]}, 16'h0808)
    trigIn <= 8'h69;
    refClkIn <= 1'h1;
    wr(REG_TRIG_CTRL, 32'h0001_F03C);
    repeat (2) @(posedge core_clk);
    `CHK({trigOut, trigOe, starOut, starOe}, {8'h3C, 8'hF0, 2'h2})
    rdChk(REG_TRIG_CTRL, 32'h0100_F069);
    rdChk(8'h20, 32'h0);
    wr(REG_IRQ_MASK, 32'h0000_0001);
    waitRun(WAIT_HIGH, 32'h5, 0, 1'h1, 9);
    waitRun(WAIT_HIGH, 32'h0, 0, 1'h1, 4);
    rdChk(REG_IRQ_STATUS, 32'h0000_0002);
    `CHK(irq, 1'h0)
    wr(REG_IRQ_STATUS, 32'h0000_0003);
    waitRun(WAIT_RISE, 32'hFFFF_FFFF, 60, 1'h0, 0);
    waitRun(WAIT_HIGH, 32'h0, 0, 1'h0, 0);
    rdChk(REG_IRQ_STATUS, 32'h0000_0001);
    `CHK(irq, 1'h1)
    wr(REG_IRQ_STATUS, 32'h0000_0001);
    rdChk(REG_IRQ_STATUS, 32'h0000_0000);
    `CHK(irq, 1'h0)
    waitRun(WAIT_FALL, 32'h32, 8, 1'h0, 0);
    waitRun(WAIT_LOW, 32'h0, 0, 1'h0, 0);
    waitRun(WAIT_FALL, 32'h14, 5, 1'h1, 24);
    waitRun(WAIT_ANY, 32'h32, 6, 1'h0, 0);
    waitRun(WAIT_ANY, 32'h32, 6, 1'h0, 0);
    waitRun(WAIT_RISE, 32'h3, 0, 1'h1, 7);
    summarize;
  end
endmodule
